/* shared/asrm_pkg.sv */
// Constants, register map and source bundle for the audio routing matrix
package asrm_pkg;

    localparam int REG_AW       = 4;
    localparam int DATA_W       = 32;
    localparam int NUM_PIN_BUF  = 20;
    localparam int NUM_SPORT    = 6;

    localparam int CLK_SEL_W    = 5;
    localparam int DAT_SEL_W    = 6;
    localparam int FS_SEL_W     = 5;
    localparam int CLK_PER_REG  = 6;
    localparam int DAT_PER_REG  = 5;
    localparam int FS_PER_REG   = 6;
    localparam int NUM_CLK_REGS = 5;
    localparam int NUM_DAT_REGS = 5;
    localparam int NUM_FS_REGS  = 4;
    localparam int NUM_CLK_FLD  = CLK_PER_REG * NUM_CLK_REGS;
    localparam int NUM_DAT_FLD  = DAT_PER_REG * NUM_DAT_REGS;
    localparam int NUM_FS_FLD   = FS_PER_REG * NUM_FS_REGS;
    localparam int NUM_REGS     = NUM_CLK_REGS + NUM_DAT_REGS + NUM_FS_REGS;

    // Register indices
    localparam int REG_CLK0     = 32'h0;
    localparam int REG_DAT0     = 32'h5;
    localparam int REG_FS0      = 32'hA;
    localparam int REG_CLK3     = 32'h3;
    localparam int REG_CLK4     = 32'h4;
    localparam logic [DATA_W-1:0] REG_FIELD_MASK = 32'h3FFF_FFFF;

    // Group A codes
    localparam int A_PB_FIRST   = 32'h0;
    localparam int A_SP_CLK     = 32'h14;
    localparam int A_RX_CLK     = 32'h1A;
    localparam int A_RX_TDM     = 32'h1B;
    localparam int A_GEN_A      = 32'h1C;
    localparam int A_GEN_B      = 32'h1D;
    localparam int A_LOW        = 32'h1E;
    localparam int A_HIGH       = 32'h1F;
    // Group B codes
    localparam int B_SP_DATA    = 32'h14;
    localparam int B_LAST       = 32'h1F;
    localparam int B_RST        = 32'h3E;
    // Group C codes
    localparam int C_SP_FS      = 32'h14;
    localparam int C_RX_FS      = 32'h1A;
    localparam int C_TX_OUT     = 32'h1B;
    localparam int C_GEN_A_FS   = 32'h1C;
    localparam int C_GEN_B_FS   = 32'h1D;
    localparam int C_LOW        = 32'h1E;
    localparam int C_HIGH       = 32'h1F;

    // Loop-breaking codes in the fifth clock register
    localparam logic [CLK_SEL_W-1:0] GEN_A_SELF = 5'h1C;
    localparam logic [CLK_SEL_W-1:0] GEN_B_SELF = 5'h1D;
    localparam int EXT_A_LSB    = 32'h0;
    localparam int EXT_B_LSB    = 32'h5;

    typedef struct packed {
        logic [NUM_PIN_BUF-1:0] pin_buf;
        logic [NUM_SPORT-1:0]   sp_clk;
        logic [NUM_SPORT-1:0]   sp_data_a;
        logic [NUM_SPORT-1:0]   sp_data_b;
        logic [NUM_SPORT-1:0]   sp_fs;
        logic                   rx_clk;
        logic                   rx_tdm_clk;
        logic                   rx_fs;
        logic                   tx_out;
        logic                   gen_a_clk;
        logic                   gen_b_clk;
        logic                   gen_a_fs;
        logic                   gen_b_fs;
    } asrm_src_t;

endpackage : asrm_pkg

/* logic/asrm_mux.sv */
// One routing multiplexer: selection code picks a bit of the source vector
`timescale 1ns/10ps
module asrm_mux #(
    parameter int SEL_W = 5
) (
    input  wire logic [(2**SEL_W)-1:0] src_i,
    input  wire logic [SEL_W-1:0]      sel_i,
    output logic                       out_o
);
    assign out_o = src_i[sel_i];
endmodule : asrm_mux

/* logic/asrm_router.sv */
// Audio signal routing matrix: selection registers and routing crossbar
//
// Function
// - Each clock input follows its 5-bit field; 0x0-0x13 pick buffers 1-20.
// - Clock codes 0x14-0x19 pick port 0-5 clocks, 0x1B the receiver TDM clock.
// - Clock code 0x1A picks the receiver recovered clock.
// - Clock codes 0x1C and 0x1D pick generator A and B clock outputs.
// - Clock codes 0x1E and 0x1F tie the input low and high.
// - Generator external inputs route from clock register 3, A 4-0, B 9-5.
// - Code 28 in bits 4-0 of clock register 4 forces generator A input low.
// - Code 29 in bits 9-5 of clock register 4 forces generator B input low.
// - Each serial data input follows its own 6-bit field.
// - Data codes 0x0-0x13 pick buffers, 0x14-0x1F port data, A even, B odd.
// - Every frame-sync input has its own field choosing its frame sync.
// - Frame-sync codes 0x0-0x13 pick pin buffers, 0x14-0x19 port frame syncs.
`timescale 1ns/10ps
module asrm_router
    import asrm_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   resetn_i,
    input  wire logic [REG_AW-1:0]      addr_i,
    input  wire logic [DATA_W-1:0]      wr_data_i,
    input  wire logic                   wr_en_i,
    input  wire logic                   rd_en_i,
    output logic      [DATA_W-1:0]      rd_data_o,
    input  wire asrm_src_t              src_i,
    output logic      [NUM_CLK_FLD-1:0] clk_in_o,
    output logic      [NUM_DAT_FLD-1:0] dat_in_o,
    output logic      [NUM_FS_FLD-1:0]  fs_in_o,
    output logic                        gen_a_ext_o,
    output logic                        gen_b_ext_o
);

    function automatic logic [DATA_W-1:0] reset_val(input int idx);
        logic [DATA_W-1:0] v;
        v = '0;
        if (idx >= REG_DAT0 && idx < REG_FS0) begin
            for (int f = 0; f < DAT_PER_REG; f++) begin
                v[f*DAT_SEL_W +: DAT_SEL_W] = DAT_SEL_W'(B_RST);
            end
        end else begin
            for (int f = 0; f < CLK_PER_REG; f++) begin
                v[f*CLK_SEL_W +: CLK_SEL_W] = CLK_SEL_W'(A_LOW);
            end
        end
        return v;
    endfunction : reset_val

    function automatic logic addr_ok(input logic [REG_AW-1:0] a);
        return int'(a) < NUM_REGS;
    endfunction : addr_ok

    logic [DATA_W-1:0] regs_q [NUM_REGS];
    logic [DATA_W-1:0] regs_d [NUM_REGS];
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;

    // Register file
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        rd_data_d = '0;
        if (wr_en_i && addr_ok(addr_i)) begin
            regs_d[addr_i] = wr_data_i & REG_FIELD_MASK;
        end
        if (rd_en_i && addr_ok(addr_i)) begin
            rd_data_d = regs_q[addr_i];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= reset_val(i);
            end
            rd_data_q <= '0;
        end else begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs_q[i] <= regs_d[i];
            end
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;

    // Source vectors per group, unused codes held low
    logic [(2**CLK_SEL_W)-1:0] src_a;
    logic [(2**DAT_SEL_W)-1:0] src_b;
    logic [(2**FS_SEL_W)-1:0]  src_c;

    always_comb begin
        src_a = '0;
        src_a[A_PB_FIRST +: NUM_PIN_BUF] = src_i.pin_buf;
        src_a[A_SP_CLK +: NUM_SPORT] = src_i.sp_clk;
        src_a[A_RX_TDM] = src_i.rx_tdm_clk;
        src_a[A_RX_CLK] = src_i.rx_clk;
        src_a[A_GEN_A] = src_i.gen_a_clk;
        src_a[A_GEN_B] = src_i.gen_b_clk;
        src_a[A_LOW] = 1'b0;
        src_a[A_HIGH] = 1'b1;
        src_b = '0;
        src_b[A_PB_FIRST +: NUM_PIN_BUF] = src_i.pin_buf;
        for (int p = 0; p < NUM_SPORT; p++) begin
            src_b[B_SP_DATA + 2*p] = src_i.sp_data_a[p];
            src_b[B_SP_DATA + 2*p + 1] = src_i.sp_data_b[p];
        end
        src_c = '0;
        src_c[A_PB_FIRST +: NUM_PIN_BUF] = src_i.pin_buf;
        src_c[C_SP_FS +: NUM_SPORT] = src_i.sp_fs;
        src_c[C_RX_FS] = src_i.rx_fs;
        src_c[C_TX_OUT] = src_i.tx_out;
        src_c[C_GEN_A_FS] = src_i.gen_a_fs;
        src_c[C_GEN_B_FS] = src_i.gen_b_fs;
        src_c[C_LOW] = 1'b0;
        src_c[C_HIGH] = 1'b1;
    end

    // Crossbar, one multiplexer per routed input
    genvar g;
    generate
        for (g = 0; g < NUM_CLK_FLD; g++) begin : g_clk
            asrm_mux #(.SEL_W(CLK_SEL_W)) u_mux (
                .src_i (src_a),
                .sel_i (regs_q[REG_CLK0 + g/CLK_PER_REG]
                              [(g%CLK_PER_REG)*CLK_SEL_W +: CLK_SEL_W]),
                .out_o (clk_in_o[g])
            );
        end
        for (g = 0; g < NUM_DAT_FLD; g++) begin : g_dat
            asrm_mux #(.SEL_W(DAT_SEL_W)) u_mux (
                .src_i (src_b),
                .sel_i (regs_q[REG_DAT0 + g/DAT_PER_REG]
                              [(g%DAT_PER_REG)*DAT_SEL_W +: DAT_SEL_W]),
                .out_o (dat_in_o[g])
            );
        end
        for (g = 0; g < NUM_FS_FLD; g++) begin : g_fs
            asrm_mux #(.SEL_W(FS_SEL_W)) u_mux (
                .src_i (src_c),
                .sel_i (regs_q[REG_FS0 + g/FS_PER_REG]
                              [(g%FS_PER_REG)*FS_SEL_W +: FS_SEL_W]),
                .out_o (fs_in_o[g])
            );
        end
    endgenerate

    // Generator external inputs, with loop breaking
    logic ext_a_raw;
    logic ext_b_raw;
    logic ext_a_kill;
    logic ext_b_kill;

    asrm_mux #(.SEL_W(CLK_SEL_W)) u_ext_a (
        .src_i (src_a),
        .sel_i (regs_q[REG_CLK3][EXT_A_LSB +: CLK_SEL_W]),
        .out_o (ext_a_raw)
    );
    asrm_mux #(.SEL_W(CLK_SEL_W)) u_ext_b (
        .src_i (src_a),
        .sel_i (regs_q[REG_CLK3][EXT_B_LSB +: CLK_SEL_W]),
        .out_o (ext_b_raw)
    );

    assign ext_a_kill = regs_q[REG_CLK4][EXT_A_LSB +: CLK_SEL_W] == GEN_A_SELF;
    assign ext_b_kill = regs_q[REG_CLK4][EXT_B_LSB +: CLK_SEL_W] == GEN_B_SELF;
    assign gen_a_ext_o = ext_a_raw & ~ext_a_kill;
    assign gen_b_ext_o = ext_b_raw & ~ext_b_kill;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    logic [CLK_SEL_W-1:0] sel_c0;
    logic [DAT_SEL_W-1:0] sel_d0;
    logic [FS_SEL_W-1:0]  sel_f0;
    assign sel_c0 = regs_q[REG_CLK0][CLK_SEL_W-1:0];
    assign sel_d0 = regs_q[REG_DAT0][DAT_SEL_W-1:0];
    assign sel_f0 = regs_q[REG_FS0][FS_SEL_W-1:0];

    sequence s_wr_clk0;
        wr_en_i && addr_i == REG_AW'(REG_CLK0);
    endsequence
    sequence s_rd_any;
        rd_en_i && addr_ok(addr_i);
    endsequence

    chk_clk_pin_buf: assert property (
        int'(sel_c0) < NUM_PIN_BUF |-> clk_in_o[0] == src_i.pin_buf[sel_c0])
        else $error("clock input 0 not following pin buffer");
    chk_clk_sport: assert property (
        int'(sel_c0) >= A_SP_CLK && int'(sel_c0) < A_RX_CLK
        |-> clk_in_o[0] == src_i.sp_clk[int'(sel_c0) - A_SP_CLK])
        else $error("clock input 0 not following port clock");
    chk_clk_rx: assert property (
        int'(sel_c0) == A_RX_CLK |-> clk_in_o[0] == src_i.rx_clk)
        else $error("clock input 0 not following receiver clock");
    chk_clk_gen: assert property (
        int'(sel_c0) == A_GEN_B |-> clk_in_o[0] == src_i.gen_b_clk)
        else $error("clock input 0 not following generator B");
    chk_clk_const: assert property (
        int'(sel_c0) == A_HIGH |-> clk_in_o[0])
        else $error("constant high code not high");
    chk_ext_a_low: assert property (
        ext_a_kill |-> !gen_a_ext_o)
        else $error("generator A external input not forced low");
    chk_ext_b_low: assert property (
        ext_b_kill |-> !gen_b_ext_o)
        else $error("generator B external input not forced low");
    chk_ext_a_src: assert property (
        !ext_a_kill && int'(regs_q[REG_CLK3][EXT_A_LSB +: CLK_SEL_W]) == A_HIGH
        |-> gen_a_ext_o)
        else $error("generator A external source wrong");
    chk_dat_odd_b: assert property (
        int'(sel_d0) == B_SP_DATA + 1 |-> dat_in_o[0] == src_i.sp_data_b[0])
        else $error("data input 0 not following port 0 B data");
    chk_fs_sport: assert property (
        int'(sel_f0) == C_SP_FS |-> fs_in_o[0] == src_i.sp_fs[0])
        else $error("frame sync 0 not following port 0 frame sync");
    chk_undef_low: assert property (
        int'(sel_d0) > B_LAST |-> !dat_in_o[0])
        else $error("undefined data code not low");
    chk_wr_takes_effect: assert property (
        s_wr_clk0 |=> sel_c0 == $past(wr_data_i[CLK_SEL_W-1:0]))
        else $error("clock field write not applied next cycle");
    chk_rd_timing: assert property (
        s_rd_any |=> rd_data_o == $past(regs_q[addr_i]) ##1 rd_data_o == '0
        || $past(rd_en_i))
        else $error("read data not in the cycle after the strobe");

endmodule : asrm_router

/* verification/asrm_src_model.sv */
// Source side model: pin buffers, serial ports, receiver and generators
`timescale 1ns/10ps
module asrm_src_model
    import asrm_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      resetn_i,
    input  wire asrm_src_t value_i,
    output asrm_src_t      src_o
);
    asrm_src_t src_d;
    asrm_src_t src_q;
    // Source levels move only on the clock edge, as the real outputs do
    always_comb begin
        src_d = resetn_i ? value_i : '0;
    end
    always_ff @(posedge clk_i) begin
        src_q <= src_d;
    end
    assign src_o = src_q;
endmodule : asrm_src_model

/* verification/asrm_router_bench.sv */
// Self-checking bench for the audio routing matrix
`timescale 1ns/10ps
module asrm_router_bench;
    import asrm_pkg::*;
    localparam int RW = NUM_CLK_FLD + NUM_DAT_FLD + NUM_FS_FLD + 2;
    typedef struct packed {
        logic          is_rd;
        logic [RW-1:0] val;
    } asrm_note_t;
    logic                   clk_i = 1'b0;
    logic                   resetn_i = 1'b0;
    logic [REG_AW-1:0]      addr_i = '0;
    logic [DATA_W-1:0]      wr_data_i = '0;
    logic                   wr_en_i = 1'b0;
    logic                   rd_en_i = 1'b0;
    logic [DATA_W-1:0]      rd_data_o;
    asrm_src_t              src_i;
    asrm_src_t              src_val = '0;
    logic [NUM_CLK_FLD-1:0] clk_in_o;
    logic [NUM_DAT_FLD-1:0] dat_in_o;
    logic [NUM_FS_FLD-1:0]  fs_in_o;
    logic                   gen_a_ext_o;
    logic                   gen_b_ext_o;
    logic                   look_rd_q = 1'b0;
    logic                   route_chk = 1'b0;
    logic [DATA_W-1:0]      shadow [NUM_REGS];
    logic [RW-1:0]          seen;
    logic [63:0]            rnd;
    asrm_note_t             note;
    asrm_note_t             notes [$];
    int                     miscompares = 0;
    int                     total_checks = 0;
    int                     cycles = 0;
    int                     seed = 9265;

    asrm_src_model asrm_src_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .value_i(src_val), .src_o(src_i));
    asrm_router asrm_router_i (.clk_i(clk_i), .resetn_i(resetn_i),
        .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .src_i(src_i),
        .clk_in_o(clk_in_o), .dat_in_o(dat_in_o), .fs_in_o(fs_in_o),
        .gen_a_ext_o(gen_a_ext_o), .gen_b_ext_o(gen_b_ext_o));

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    function automatic logic pick_a(logic [4:0] c, asrm_src_t s);
        if (c < 5'h14) return s.pin_buf[c];
        if (c < 5'h1A) return s.sp_clk[c - 5'h14];
        case (c)
            5'h1A:   return s.rx_clk;
            5'h1B:   return s.rx_tdm_clk;
            5'h1C:   return s.gen_a_clk;
            5'h1D:   return s.gen_b_clk;
            5'h1E:   return 1'b0;
            default: return 1'b1;
        endcase
    endfunction : pick_a

    function automatic logic pick_b(logic [5:0] c, asrm_src_t s);
        if (c < 6'h14) return s.pin_buf[c];
        if (c >= 6'h20) return 1'b0;
        if (c[0]) return s.sp_data_b[(c - 6'h14) >> 1];
        return s.sp_data_a[(c - 6'h14) >> 1];
    endfunction : pick_b

    function automatic logic pick_c(logic [4:0] c, asrm_src_t s);
        if (c < 5'h14) return s.pin_buf[c];
        if (c < 5'h1A) return s.sp_fs[c - 5'h14];
        case (c)
            5'h1A:   return s.rx_fs;
            5'h1B:   return s.tx_out;
            5'h1C:   return s.gen_a_fs;
            5'h1D:   return s.gen_b_fs;
            5'h1E:   return 1'b0;
            default: return 1'b1;
        endcase
    endfunction : pick_c

    // Expected routed outputs from shadow registers and source levels
    function automatic logic [RW-1:0] route_exp(asrm_src_t s);
        logic [RW-1:0] v;
        v = '0;
        for (int n = 0; n < NUM_CLK_FLD; n++)
            v[2+NUM_FS_FLD+NUM_DAT_FLD+n] =
                pick_a(shadow[n/CLK_PER_REG][5*(n%CLK_PER_REG)+:5], s);
        for (int n = 0; n < NUM_DAT_FLD; n++)
            v[2+NUM_FS_FLD+n] =
                pick_b(shadow[REG_DAT0+n/DAT_PER_REG][6*(n%DAT_PER_REG)+:6], s);
        for (int n = 0; n < NUM_FS_FLD; n++)
            v[2+n] =
                pick_c(shadow[REG_FS0+n/FS_PER_REG][5*(n%FS_PER_REG)+:5], s);
        v[1] = (shadow[REG_CLK4][4:0] == 5'd28) ? 1'b0
             : pick_a(shadow[REG_CLK3][4:0], s);
        v[0] = (shadow[REG_CLK4][9:5] == 5'd29) ? 1'b0
             : pick_a(shadow[REG_CLK3][9:5], s);
        return v;
    endfunction : route_exp

    function automatic logic [29:0] rep(int c, int w);
        logic [29:0] f;
        f = '0;
        for (int k = 0; k < 30 / w; k++) begin
            if (w == 5) f[5*k+:5] = 5'(c);
            else f[6*k+:6] = 6'(c);
        end
        return f;
    endfunction : rep

    task automatic reg_write(input int a, input logic [DATA_W-1:0] d);
        addr_i <= REG_AW'(a);
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        rd_en_i <= 1'b0;
        if (a < NUM_REGS) shadow[a] = d & REG_FIELD_MASK;
        @(posedge clk_i);
    endtask : reg_write

    task automatic reg_read(input int a);
        addr_i <= REG_AW'(a);
        rd_en_i <= 1'b1;
        wr_en_i <= 1'b0;
        notes.push_back({1'b1, RW'(a < NUM_REGS ? shadow[a] : 32'h0)});
        @(posedge clk_i);
    endtask : reg_read

    task automatic idle;
        wr_en_i <= 1'b0;
        rd_en_i <= 1'b0;
        @(posedge clk_i);
    endtask : idle

    task automatic check_route;
        idle();
        notes.push_back({1'b0, route_exp(src_val)});
        route_chk <= 1'b1;
        @(posedge clk_i);
        route_chk <= 1'b0;
    endtask : check_route

    task automatic new_src;
        rnd = {$random(seed), $random(seed)};
        src_val <= rnd[$bits(asrm_src_t)-1:0];
    endtask : new_src

    task test_done;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // Result watcher: read data one cycle after the strobe, routes on request
    always @(posedge clk_i) begin
        look_rd_q <= rd_en_i;
        cycles++;
        if (look_rd_q || route_chk) begin
            note = notes.pop_front();
            seen = note.is_rd ? RW'(rd_data_o)
                 : {clk_in_o, dat_in_o, fs_in_o, gen_a_ext_o, gen_b_ext_o};
            total_checks++;
            if (seen !== note.val) begin
                $display("unexpected %s: expected %h seen %h",
                         note.is_rd ? "rd_data_o" : "routed", note.val, seen);
                miscompares++;
            end
        end
        if (cycles == 5000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        for (int r = 0; r < NUM_REGS; r++)
            shadow[r] = {2'b00, (r >= REG_DAT0 && r < REG_FS0) ? rep(B_RST, 6)
                                                               : rep(A_LOW, 5)};
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (int a = 0; a < 16; a++) reg_read(a);
        check_route();
        $display("test reset done");
        for (int c = 0; c < 64; c++) begin
            new_src();
            reg_write(c % 5, {2'($random(seed)), rep(c % 32, 5)});
            reg_write(REG_DAT0 + c % 5, {2'($random(seed)), rep(c, 6)});
            reg_write(REG_FS0 + c % 4, {2'($random(seed)), rep(c % 32, 5)});
            reg_read(REG_DAT0 + c % 5);
            check_route();
            check_route();
        end
        $display("test code sweep done");
        src_val <= '1;
        reg_write(REG_CLK3, {22'h0, GEN_B_SELF, GEN_A_SELF});
        reg_write(REG_CLK4, 32'h0);
        check_route();
        reg_write(REG_CLK4, {22'h0, GEN_B_SELF, GEN_A_SELF});
        check_route();
        reg_write(REG_CLK4, {22'h0, GEN_A_SELF, GEN_B_SELF});
        check_route();
        $display("test generator input done");
        repeat (40) begin
            new_src();
            reg_write($unsigned($random(seed)) % 16, $random(seed));
            reg_read($unsigned($random(seed)) % 16);
            check_route();
        end
        $display("test random access done");
        idle();
        idle();
        test_done();
    end
endmodule : asrm_router_bench
